/* File: shared/spmap_pkg.sv */
// Shared constants for the sector protection map link: opcodes, map size,
// host command codes and timing counts.
// Assumes a single 40 MHz system clock on both ends.
package spmap_pkg;

	// ********************************************************************
	// Map geometry and codes
	// ********************************************************************
	localparam int       MAP_BYTES    = 32;
	localparam int       BUF1_DEPTH   = 264;
	localparam logic [7:0] MAP_PROT   = 8'hFF;
	localparam logic [7:0] MAP_UNPROT = 8'h00;
	localparam int       SUB0A_HI     = 7;
	localparam int       SUB0B_HI     = 5;
	localparam logic [1:0] SUB_PROT   = 2'h3;

	// ********************************************************************
	// Command bytes
	// ********************************************************************
	localparam logic [7:0] PFX0      = 8'h3D;
	localparam logic [7:0] PFX1      = 8'h2A;
	localparam logic [7:0] PFX2      = 8'h7F;
	localparam logic [7:0] OPC_ERASE = 8'hCF;
	localparam logic [7:0] OPC_PROG  = 8'hFC;
	localparam logic [7:0] OPC_READ  = 8'h32;
	localparam logic [7:0] DUMMY     = 8'h00;
	localparam int       CMD_BYTES   = 4;
	localparam int       DUMMY_BYTES = 3;

	typedef enum logic [1:0] {
		SPMAP_ERASE,
		SPMAP_PROGRAM,
		SPMAP_READ
	} spmap_cmd_e;

	// ********************************************************************
	// Timing
	// ********************************************************************
	localparam int SYS_CLK_PERIOD_NS          = 25;
	// Longest times; cycle counts round down
	localparam int PROTECT_MAP_ERASE_TIME_US  = 100;
	localparam int PAGE_PROGRAM_TIME_US       = 100;
	localparam int ERASE_CYC =
		(PROTECT_MAP_ERASE_TIME_US * 1000) / SYS_CLK_PERIOD_NS;
	localparam int PROG_CYC =
		(PAGE_PROGRAM_TIME_US * 1000) / SYS_CLK_PERIOD_NS;
	// Half serial clock period; must cover the device's input synchroniser
	localparam int SCK_HALF_CYC = 8;
	localparam int ENDURANCE_CYCLES = 10000;

endpackage : spmap_pkg

/* File: shared/spmap_if.sv */
// Serial link between the protection map device end and its host end.
// The serial output is a tristate pin; the line is resolved here.
`timescale 1ns/1ps
interface spmap_if;
	logic sck;
	logic cs_n;
	logic mosi;
	logic so;
	logic so_oe;
	logic so_line;

	// Undriven output floats high through an assumed pull-up
	assign so_line = so_oe ? so : 1'b1;

	modport dev (
		input  sck,
		input  cs_n,
		input  mosi,
		output so,
		output so_oe
	);

	modport host (
		output sck,
		output cs_n,
		output mosi,
		input  so_line
	);
endinterface : spmap_if

/* File: logic/spmap_device.sv */
// Device end: decodes serial commands for the nonvolatile protection map,
// runs the self-timed erase and program cycles, and shifts the map out.
// Assumes link pins are asynchronous to i_sys_clk and the serial clock is
// slow enough (half period of at least four system clocks) to be sampled.
`timescale 1ns/1ps

// Behaviour
// - Keep thirty-two map bytes, one per sector
// - FFh protects sectors 1-31, 00h unprotects
// - Byte 0 bits 7:6, 5:4 guard sub-sectors
// - Host erases before programming new values
// - Erase sequence then deselect starts erase
// - Erase self-timed, busy shown throughout
// - Erase sets every map byte to FFh
// - Erase accepted whatever protection state
// - Program sequence, 32 bytes, deselect starts program
// - Program self-timed, busy until complete
// - Host sends all 32 data bytes; host here sends i_nbytes data bytes, as many as the caller sets
// - Write pointer wraps to location 0
// - Host writes only valid map codes; host here sends caller data unchecked
// - Program accepted while protection enabled
// - Program uses first buffer, overwriting it
// - Opcode 32h, three dummies, map shifts out
// - After byte 31 output undefined
// - Deselect ends read, output released
// - Delivered map holds 00h everywhere
// - Host limits map cycles to 10,000; host here only counts and raises o_wear_limit, it keeps issuing commands
// - Marked sectors refuse change when protection on
// - Write-protect pin blocks map erase/program
module spmap_device #(
	parameter int ERASE_CYC = spmap_pkg::ERASE_CYC,
	parameter int PROG_CYC  = spmap_pkg::PROG_CYC,
	parameter int MAP_BYTES = spmap_pkg::MAP_BYTES,
	parameter int BUF_DEPTH = spmap_pkg::BUF1_DEPTH
) (
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst_n,
	spmap_if.dev            spi,
	input  wire logic       i_wp_n,
	input  wire logic       i_prot_en,
	input  wire logic [4:0] i_chk_sector,
	input  wire logic       i_chk_sub,
	output logic            o_busy,
	output logic            o_chk_deny
);

	localparam int PW = $clog2(MAP_BYTES);
	localparam int TW = $clog2((ERASE_CYC > PROG_CYC ? ERASE_CYC : PROG_CYC)
		+ 1);
	localparam logic [PW-1:0] LAST_LOC = PW'(MAP_BYTES - 1);

	typedef enum logic [2:0] {
		SP_OPC,
		SP_PREFIX,
		SP_ERASE_ARM,
		SP_PROG,
		SP_DUMMY,
		SP_OUT,
		SP_SKIP
	} spmap_rx_e;

	typedef enum logic [1:0] {
		OP_IDLE,
		OP_ERASE,
		OP_PROG
	} spmap_op_e;

	// ********************************************************************
	// Pin synchronisers: sck, cs_n, mosi, wp_n
	// ********************************************************************
	logic [3:0] sync1;
	logic [3:0] sync2;
	logic       sck_prev;
	logic       cs_prev;

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync1    <= 4'hA;
			sync2    <= 4'hA;
			sck_prev <= 1'b0;
			cs_prev  <= 1'b1;
		end else begin
			sync1    <= {i_wp_n, spi.mosi, spi.cs_n, spi.sck};
			sync2    <= sync1;
			sck_prev <= sync2[0];
			cs_prev  <= sync2[1];
		end
	end

	wire sck_s    = sync2[0];
	wire cs_n_s   = sync2[1];
	wire mosi_s   = sync2[2];
	wire wp_n_s   = sync2[3];
	wire sck_rise = sck_s & ~sck_prev & ~cs_n_s;
	wire sck_fall = ~sck_s & sck_prev & ~cs_n_s;
	wire cs_rise  = cs_n_s & ~cs_prev;

	// ********************************************************************
	// Storage
	// ********************************************************************
	logic [7:0]    map_mem [MAP_BYTES];
	logic [7:0]    buf1    [BUF_DEPTH];
	spmap_rx_e     rx_state;
	spmap_op_e     op;
	logic [TW-1:0] timer;

	// ********************************************************************
	// Command receiver
	// ********************************************************************
	logic [6:0]    shreg;
	logic [2:0]    bit_cnt;
	logic [1:0]    byte_idx;
	logic [PW-1:0] wptr;
	logic [7:0]    rx_byte;

	assign rx_byte = {shreg, mosi_s};

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rx_state <= SP_OPC;
			shreg    <= 7'h00;
			bit_cnt  <= 3'h0;
			byte_idx <= 2'h0;
			wptr     <= '0;
		end else if (cs_n_s) begin
			rx_state <= SP_OPC;
			bit_cnt  <= 3'h0;
			byte_idx <= 2'h0;
		end else if (sck_rise) begin
			shreg   <= rx_byte[6:0];
			bit_cnt <= bit_cnt + 3'h1;
			if (bit_cnt == 3'h7) begin
				byte_idx <= byte_idx + 2'h1;
				unique case (rx_state)
					SP_OPC: begin
						if (rx_byte == spmap_pkg::OPC_READ) begin
							rx_state <= SP_DUMMY;
						end else if (rx_byte == spmap_pkg::PFX0) begin
							rx_state <= SP_PREFIX;
						end else begin
							rx_state <= SP_SKIP;
						end
					end
					SP_PREFIX: begin
						if (byte_idx == 2'h1 && rx_byte == spmap_pkg::PFX1) begin
							rx_state <= SP_PREFIX;
						end else if (byte_idx == 2'h2
							&& rx_byte == spmap_pkg::PFX2) begin
							rx_state <= SP_PREFIX;
						end else if (byte_idx == 2'h3
							&& rx_byte == spmap_pkg::OPC_ERASE) begin
							rx_state <= SP_ERASE_ARM;
						end else if (byte_idx == 2'h3
							&& rx_byte == spmap_pkg::OPC_PROG) begin
							rx_state <= SP_PROG;
							wptr     <= '0;
						end else begin
							rx_state <= SP_SKIP;
						end
					end
					// Trailing bytes after the erase opcode cancel it
					SP_ERASE_ARM: rx_state <= SP_SKIP;
					SP_PROG: begin
						buf1[wptr] <= rx_byte;
						wptr <= (wptr == LAST_LOC) ? '0 : wptr + 1'b1;
					end
					SP_DUMMY: begin
						if (byte_idx == 2'(spmap_pkg::DUMMY_BYTES)) begin
							rx_state <= SP_OUT;
						end
					end
					SP_OUT:  rx_state <= SP_OUT;
					SP_SKIP: rx_state <= SP_SKIP;
				endcase
			end
		end
	end

	// ********************************************************************
	// Read-out shifter, updated on falling serial clock
	// ********************************************************************
	logic [PW:0] rptr;
	logic [2:0]  obit;
	logic [7:0]  cur_byte;

	assign cur_byte = map_mem[rptr[PW-1:0]];

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			spi.so    <= 1'b0;
			spi.so_oe <= 1'b0;
			rptr      <= '0;
			obit      <= 3'h0;
		end else if (cs_n_s) begin
			spi.so_oe <= 1'b0;
			rptr      <= '0;
			obit      <= 3'h0;
		end else if (sck_fall && rx_state == SP_OUT) begin
			spi.so_oe <= 1'b1;
			obit      <= obit + 3'h1;
			// Past the last location the pin just reads low
			if (rptr[PW]) begin
				spi.so <= 1'b0;
			end else begin
				spi.so <= cur_byte[3'h7 - obit];
				if (obit == 3'h7) begin
					rptr <= rptr + 1'b1;
				end
			end
		end
	end

	// ********************************************************************
	// Self-timed erase and program cycles
	// ********************************************************************
	// Write-protect blocks both; global protection state does not
	wire start_erase = cs_rise && rx_state == SP_ERASE_ARM
		&& op == OP_IDLE && wp_n_s;
	wire start_prog  = cs_rise && rx_state == SP_PROG
		&& op == OP_IDLE && wp_n_s;

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			op    <= OP_IDLE;
			timer <= '0;
			for (int i = 0; i < MAP_BYTES; i++) begin
				map_mem[i] <= spmap_pkg::MAP_UNPROT;
			end
		end else if (start_erase) begin
			op    <= OP_ERASE;
			timer <= TW'(ERASE_CYC - 1);
		end else if (start_prog) begin
			op    <= OP_PROG;
			timer <= TW'(PROG_CYC - 1);
		end else if (op != OP_IDLE) begin
			if (timer == '0) begin
				op <= OP_IDLE;
				for (int i = 0; i < MAP_BYTES; i++) begin
					if (op == OP_ERASE) begin
						map_mem[i] <= spmap_pkg::MAP_PROT;
					end else begin
						// Programming only clears bits
						map_mem[i] <= map_mem[i] & buf1[i];
					end
				end
			end else begin
				timer <= timer - 1'b1;
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_busy <= 1'b0;
		end else begin
			o_busy <= (op != OP_IDLE) || start_erase || start_prog;
		end
	end

	// ********************************************************************
	// Sector guard for main array program/erase
	// ********************************************************************
	logic [7:0] chk_byte;
	logic       chk_marked;

	always_comb begin
		chk_byte   = map_mem[i_chk_sector];
		chk_marked = (chk_byte == spmap_pkg::MAP_PROT);
		if (i_chk_sector == 5'h00) begin
			chk_marked = i_chk_sub
				? chk_byte[spmap_pkg::SUB0B_HI -: 2] == spmap_pkg::SUB_PROT
				: chk_byte[spmap_pkg::SUB0A_HI -: 2] == spmap_pkg::SUB_PROT;
		end
	end

	// Pin protection acts even when software protection is off
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_chk_deny <= 1'b0;
		end else begin
			o_chk_deny <= chk_marked && (i_prot_en || !wp_n_s);
		end
	end

endmodule : spmap_device

/* File: logic/spmap_host.sv */
// Host end: issues map erase, program and read over the serial link in
// mode 0, making the serial clock from i_sys_clk by a divider.
// Assumes the caller waits for the device's busy time after erase/program.
`timescale 1ns/1ps
module spmap_host #(
	parameter int SCK_HALF  = spmap_pkg::SCK_HALF_CYC,
	parameter int MAP_BYTES = spmap_pkg::MAP_BYTES
) (
	input  wire logic                  i_sys_clk,
	input  wire logic                  i_rst_n,
	spmap_if.host                      spi,
	input  wire logic                  i_start,
	input  wire spmap_pkg::spmap_cmd_e i_cmd,
	input  wire logic [5:0]            i_nbytes,
	input  wire logic [7:0]            i_wdata,
	output logic                       o_wtake,
	output logic [7:0]                 o_rdata,
	output logic                       o_rvalid,
	output logic                       o_busy,
	output logic                       o_done,
	output logic                       o_refused,
	output logic                       o_wear_limit
);

	localparam int DW = $clog2(SCK_HALF * 2 + 1);

	typedef enum logic [1:0] {
		HS_IDLE,
		HS_SHIFT,
		HS_GAP
	} spmap_hst_e;

	function automatic logic [7:0] spmap_byte_at(
		input spmap_pkg::spmap_cmd_e cmd,
		input logic [6:0]            idx,
		input logic [7:0]            wdata
	);
		logic rd;
		rd = (cmd == spmap_pkg::SPMAP_READ);
		unique case (idx)
			7'h00:   spmap_byte_at = rd ? spmap_pkg::OPC_READ : spmap_pkg::PFX0;
			7'h01:   spmap_byte_at = rd ? spmap_pkg::DUMMY : spmap_pkg::PFX1;
			7'h02:   spmap_byte_at = rd ? spmap_pkg::DUMMY : spmap_pkg::PFX2;
			7'h03:   spmap_byte_at = rd ? spmap_pkg::DUMMY
				: (cmd == spmap_pkg::SPMAP_ERASE ? spmap_pkg::OPC_ERASE
				: spmap_pkg::OPC_PROG);
			// Caller data goes out untouched; valid codes are its duty
			default: spmap_byte_at = (cmd == spmap_pkg::SPMAP_PROGRAM)
				? wdata : spmap_pkg::DUMMY;
		endcase
	endfunction : spmap_byte_at

	spmap_hst_e            state;
	spmap_pkg::spmap_cmd_e cmd;
	logic [DW-1:0]         div;
	logic [2:0]            bit_cnt;
	logic [6:0]            idx;
	logic [6:0]            total;
	logic [7:0]            txsh;
	logic [7:0]            rxsh;
	logic [7:0]            next_byte;
	logic [7:0]            first_byte;
	logic                  erased;
	logic [13:0]           wear;

	assign next_byte = spmap_byte_at(cmd, idx + 7'h01, i_wdata);
	assign first_byte = spmap_byte_at(i_cmd, 7'h00, i_wdata);

	// ********************************************************************
	// Transfer engine
	// ********************************************************************
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state     <= HS_IDLE;
			cmd       <= spmap_pkg::SPMAP_ERASE;
			spi.sck   <= 1'b0;
			spi.cs_n  <= 1'b1;
			spi.mosi  <= 1'b0;
			div       <= '0;
			bit_cnt   <= 3'h0;
			idx       <= 7'h00;
			total     <= 7'h00;
			txsh      <= 8'h00;
			rxsh      <= 8'h00;
			o_wtake   <= 1'b0;
			o_rdata   <= 8'h00;
			o_rvalid  <= 1'b0;
			o_busy    <= 1'b0;
			o_done    <= 1'b0;
			o_refused <= 1'b0;
		end else begin
			o_wtake   <= 1'b0;
			o_rvalid  <= 1'b0;
			o_done    <= 1'b0;
			o_refused <= 1'b0;
			unique case (state)
				HS_IDLE: begin
					if (i_start) begin
						if (i_cmd == spmap_pkg::SPMAP_PROGRAM && !erased) begin
							o_refused <= 1'b1;
							o_done    <= 1'b1;
						end else begin
							cmd      <= i_cmd;
							state    <= HS_SHIFT;
							o_busy   <= 1'b1;
							spi.cs_n <= 1'b0;
							div      <= '0;
							bit_cnt  <= 3'h0;
							idx      <= 7'h00;
							txsh     <= first_byte;
							spi.mosi <= first_byte[7];
							unique case (i_cmd)
								spmap_pkg::SPMAP_PROGRAM:
									total <= 7'(spmap_pkg::CMD_BYTES) + {1'b0, i_nbytes};
								spmap_pkg::SPMAP_READ:
									total <= 7'(spmap_pkg::CMD_BYTES + MAP_BYTES);
								default:
									total <= 7'(spmap_pkg::CMD_BYTES);
							endcase
						end
					end
				end
				HS_SHIFT: begin
					div <= div + 1'b1;
					if (div == DW'(SCK_HALF - 1)) begin
						div     <= '0;
						spi.sck <= ~spi.sck;
						if (!spi.sck) begin
							rxsh <= {rxsh[6:0], spi.so_line};
						end else begin
							bit_cnt <= bit_cnt + 3'h1;
							txsh    <= {txsh[6:0], 1'b0};
							spi.mosi <= txsh[6];
							if (bit_cnt == 3'h7) begin
								idx <= idx + 7'h01;
								if (cmd == spmap_pkg::SPMAP_READ
									&& idx >= 7'(spmap_pkg::CMD_BYTES)) begin
									o_rdata  <= rxsh;
									o_rvalid <= 1'b1;
								end
								if (idx + 7'h01 == total) begin
									spi.cs_n <= 1'b1;
									state    <= HS_GAP;
								end else begin
									txsh     <= next_byte;
									spi.mosi <= next_byte[7];
									o_wtake  <= (cmd == spmap_pkg::SPMAP_PROGRAM)
										&& idx + 7'h01 >= 7'(spmap_pkg::CMD_BYTES);
								end
							end
						end
					end
				end
				HS_GAP: begin
					// Deselect long enough for the device to see it
					div <= div + 1'b1;
					if (div == DW'(SCK_HALF * 2)) begin
						div    <= '0;
						state  <= HS_IDLE;
						o_busy <= 1'b0;
						o_done <= 1'b1;
					end
				end
				default: state <= HS_IDLE;
			endcase
		end
	end

	// ********************************************************************
	// Erase-before-program tracking and endurance count
	// ********************************************************************
	wire fin = (state == HS_GAP) && div == DW'(SCK_HALF * 2);

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			erased       <= 1'b0;
			wear         <= 14'h0000;
			o_wear_limit <= 1'b0;
		end else if (fin && cmd != spmap_pkg::SPMAP_READ) begin
			erased <= (cmd == spmap_pkg::SPMAP_ERASE);
			if (wear != 14'(spmap_pkg::ENDURANCE_CYCLES)) begin
				wear <= wear + 14'h0001;
			end
			o_wear_limit <= (wear + 14'h0001
				>= 14'(spmap_pkg::ENDURANCE_CYCLES));
		end
	end

endmodule : spmap_host

/* File: dv/spmap_properties.sv */
// Checker for the serial link between the map host end and device end.
// Assumes the default half serial clock of eight system clocks.
`timescale 1ns/1ps
module spmap_properties (
	input  wire logic i_sys_clk,
	input  wire logic i_rst_n,
	input  wire logic sck,
	input  wire logic cs_n,
	input  wire logic mosi,
	input  wire logic so,
	input  wire logic so_oe
);
	// ********************************************************************
	// Rising serial clocks seen in the current frame
	// ********************************************************************
	logic       sck_q;
	logic [9:0] rises;

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			sck_q <= 1'b0;
		else
			sck_q <= sck;
	end

	// Ten bits: a wrapped program frame runs past 255 bits
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			rises <= 10'h000;
		else if (cs_n)
			rises <= 10'h000;
		else if (sck && !sck_q)
			rises <= rises + 10'h001;
	end

	// ********************************************************************
	// Link properties
	// ********************************************************************
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_n);

	sequence high_half;
		sck [*8] ##1 !sck;
	endsequence

	sequence lead_in;
		!sck [*8] ##1 sck;
	endsequence

	sck_idle_a: assert property (cs_n |-> !sck)
		else $error("serial clock high outside a frame");
	mosi_hold_a: assert property (sck && $past(sck) |-> $stable(mosi))
		else $error("host data moved while serial clock high");
	sck_pulse_a: assert property ($rose(sck) |-> high_half)
		else $error("serial clock high phase has wrong length");
	frame_lead_a: assert property ($fell(cs_n) |-> lead_in)
		else $error("first serial clock edge misplaced");
	whole_bytes_a: assert property ($rose(cs_n) |-> rises[2:0] == 3'h0)
		else $error("frame ended inside a byte");
	cs_gap_a: assert property ($rose(cs_n) |-> cs_n [*8])
		else $error("chip select gap too short");
	so_release_a: assert property ($rose(cs_n) |-> ##[1:8] !so_oe)
		else $error("serial output not released after deselect");
	so_late_a: assert property (so_oe && !cs_n |-> rises >= 10'd32)
		else $error("serial output driven before opcode and dummies");
	so_hold_a: assert property (so_oe && sck && $past(sck) |-> $stable(so))
		else $error("device data moved while serial clock high");
endmodule : spmap_properties

/* File: dv/sector_protect_map_access_tb.sv */
// Bench for the protection map link: host end drives the device end.
// Assumes short self-timed counts set through the device parameters.
`timescale 1ns/1ps
module sector_protect_map_access_tb;
	// ********************************************************************
	// Signals and instances
	// ********************************************************************
	localparam int CYC = 20;
	logic                  i_sys_clk = 1'b0;
	logic                  i_rst_n   = 1'b0;
	logic                  wp_n      = 1'b1;
	logic                  prot_en   = 1'b0;
	logic [4:0]            sector    = 5'h00;
	logic                  sub       = 1'b0;
	logic                  start     = 1'b0;
	spmap_pkg::spmap_cmd_e cmd       = spmap_pkg::SPMAP_READ;
	logic [5:0]            nbytes    = 6'h20;
	logic [7:0]            wdata     = 8'h00;
	logic                  dev_busy, deny, wtake, rvalid, hbusy, done;
	logic                  refused, wear, refused_seen;
	logic [7:0]            rdata;
	logic [7:0]            wr [0:32];
	logic [7:0]            rd [0:31];
	logic [7:0]            exp_map [0:31];
	int                    num_errors = 0;
	int                    samples_checked = 0;
	int                    busy_cnt, n_rd;

	spmap_if link ();
	always #12.5 i_sys_clk = ~i_sys_clk;

	spmap_device #(.ERASE_CYC(CYC), .PROG_CYC(CYC)) spmap_device_i (
		.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .spi(link), .i_wp_n(wp_n),
		.i_prot_en(prot_en), .i_chk_sector(sector), .i_chk_sub(sub),
		.o_busy(dev_busy), .o_chk_deny(deny));
	spmap_host spmap_host_i (
		.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .spi(link), .i_start(start),
		.i_cmd(cmd), .i_nbytes(nbytes), .i_wdata(wdata), .o_wtake(wtake),
		.o_rdata(rdata), .o_rvalid(rvalid), .o_busy(hbusy), .o_done(done),
		.o_refused(refused), .o_wear_limit(wear));
	spmap_properties spmap_properties_i (
		.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .sck(link.sck),
		.cs_n(link.cs_n), .mosi(link.mosi), .so(link.so), .so_oe(link.so_oe));

	// ********************************************************************
	// Shared tasks
	// ********************************************************************
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic test_done();
		if (num_errors == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done

	// Runs one command and waits until the device cycle has ended too,
	// so the next command is never dropped for a busy device
	task automatic run_cmd(input spmap_pkg::spmap_cmd_e c,
	                       input logic [5:0] n);
		int   k;
		logic got;
		k = 0;
		got = 1'b0;
		busy_cnt = 0;
		n_rd = 0;
		refused_seen = 1'b0;
		@(posedge i_sys_clk);
		start <= 1'b1;
		cmd <= c;
		nbytes <= n;
		wdata <= wr[0];
		@(posedge i_sys_clk);
		start <= 1'b0;
		while (!got || dev_busy) begin
			@(negedge i_sys_clk);
			busy_cnt += int'(dev_busy);
			if (!got)
				check(hbusy, !done);
			if (done)
				got = 1'b1;
			if (refused)
				refused_seen = 1'b1;
			if (rvalid && n_rd < 32) begin
				rd[n_rd] = rdata;
				n_rd++;
			end
			if (wtake) begin
				k++;
				@(posedge i_sys_clk);
				wdata <= wr[k % 33];
			end
		end
	endtask : run_cmd

	task automatic read_check();
		run_cmd(spmap_pkg::SPMAP_READ, 6'h20);
		check(8'(n_rd), 8'h20);
		foreach (exp_map[i])
			check(rd[i], exp_map[i]);
	endtask : read_check

	// ********************************************************************
	// Scenarios
	// ********************************************************************
	task automatic t_delivered();
		check(dev_busy, 1'b0);
		check(wear, 1'b0);
		foreach (exp_map[i])
			exp_map[i] = spmap_pkg::MAP_UNPROT;
		read_check();
	endtask : t_delivered

	task automatic t_erase();
		@(posedge i_sys_clk);
		prot_en <= 1'b1;
		run_cmd(spmap_pkg::SPMAP_ERASE, 6'h20);
		check(busy_cnt >= CYC && busy_cnt <= CYC + 2, 1'b1);
		check(refused_seen, 1'b0);
		foreach (exp_map[i])
			exp_map[i] = spmap_pkg::MAP_PROT;
		read_check();
	endtask : t_erase

	// Thirty-three bytes: the last must overwrite location 0
	task automatic t_program();
		for (int i = 0; i < 33; i++)
			wr[i] = i[0] ? 8'hFF : 8'h00;
		wr[0] = 8'hF0;
		wr[32] = 8'hC0;
		run_cmd(spmap_pkg::SPMAP_PROGRAM, 6'h21);
		check(busy_cnt >= CYC && busy_cnt <= CYC + 2, 1'b1);
		check(refused_seen, 1'b0);
		for (int i = 0; i < 32; i++)
			exp_map[i] = wr[i];
		exp_map[0] = 8'hC0;
		read_check();
	endtask : t_program

	task automatic t_no_erase();
		run_cmd(spmap_pkg::SPMAP_PROGRAM, 6'h20);
		check(refused_seen, 1'b1);
		check(busy_cnt == 0, 1'b1);
	endtask : t_no_erase

	// Entries: sector, sub-sector, enable, write-protect, expected denial
	task automatic t_query();
		logic [8:0] q [6];
		q = '{9'h007, 9'h00E, 9'h017, 9'h046, 9'h012, 9'h011};
		foreach (q[i]) begin
			@(posedge i_sys_clk);
			{sector, sub, prot_en, wp_n} <= q[i][8:1];
			repeat (6) @(posedge i_sys_clk);
			@(negedge i_sys_clk);
			check(deny, q[i][0]);
		end
	endtask : t_query

	// Write-protect still low from the query table
	task automatic t_wp_erase();
		run_cmd(spmap_pkg::SPMAP_ERASE, 6'h20);
		check(busy_cnt == 0, 1'b1);
		read_check();
	endtask : t_wp_erase

	initial begin
		repeat (10) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		t_delivered();
		t_erase();
		t_program();
		t_no_erase();
		t_query();
		t_wp_erase();
		test_done();
	end

	initial begin
		repeat (60000) @(posedge i_sys_clk);
		num_errors++;
		test_done();
	end
endmodule : sector_protect_map_access_tb
